// file: core/rccr_axil_slave.sv
`timescale 1ns/100ps
`default_nettype none
module rccr_axil_slave (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_wr_pulse,    // one cycle: write lands this edge
  output logic [3:0]       o_wr_addr,     // write address
  output logic [7:0]       o_wr_data,     // low byte of write data
  output logic             o_wr_lane0,    // byte lane 0 enabled
  output logic [3:0]       o_rd_addr,     // read address presented to the core
  input  wire logic [31:0] i_rd_data,     // read data from the core
  input  wire logic        i_rd_ok        // address is mapped
);
  typedef struct packed {
    logic              aw_have;   // address captured
    logic [3:0]        aw_addr;
    logic              w_have;    // data captured
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    rccr_pkg::rccr_bus_t rstate;  // read channel state
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } rccr_axs_t;
  rccr_axs_t s_reg;
  rccr_axs_t s_next;
  logic      wr_fire;

  // ready while the holding slot is empty and no response is pending
  assign o_awready  = !s_reg.aw_have && !s_reg.bvalid;
  assign o_wready   = !s_reg.w_have && !s_reg.bvalid;
  assign o_arready  = (s_reg.rstate == rccr_pkg::RCCR_BUS_IDLE);
  assign o_bvalid   = s_reg.bvalid;
  assign o_bresp    = s_reg.bresp;
  assign o_rvalid   = (s_reg.rstate == rccr_pkg::RCCR_BUS_RESP);
  assign o_rdata    = s_reg.rdata;
  assign o_rresp    = s_reg.rresp;
  assign o_rd_addr  = i_araddr;
  assign wr_fire    = s_reg.aw_have && s_reg.w_have;
  assign o_wr_pulse = wr_fire;
  assign o_wr_addr  = s_reg.aw_addr;
  assign o_wr_data  = s_reg.w_data;
  assign o_wr_lane0 = s_reg.w_lane0;

  // channels are taken in either order; the write commits once both are held
  always_comb begin
    s_next = s_reg;
    if (i_awvalid && o_awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      s_next.w_have  = 1'b1;
      s_next.w_data  = i_wdata[7:0];
      s_next.w_lane0 = i_wstrb[0];
    end
    if (wr_fire) begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = (s_reg.aw_addr == rccr_pkg::RCCR_OFF_CTRL) ?
                       rccr_pkg::RCCR_RESP_OKAY : rccr_pkg::RCCR_RESP_SLVERR;
    end else if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
    end
    case (s_reg.rstate)
      rccr_pkg::RCCR_BUS_IDLE: begin
        if (i_arvalid) begin
          s_next.rstate = rccr_pkg::RCCR_BUS_RESP;
          s_next.rdata  = i_rd_ok ? i_rd_data : 32'h00000000;
          s_next.rresp  = i_rd_ok ? rccr_pkg::RCCR_RESP_OKAY : rccr_pkg::RCCR_RESP_SLVERR;
        end
      end
      rccr_pkg::RCCR_BUS_RESP: begin
        if (i_rready) begin
          s_next.rstate = rccr_pkg::RCCR_BUS_IDLE;
        end
      end
      default: begin
        s_next.rstate = rccr_pkg::RCCR_BUS_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // rccr_axil_slave
`default_nettype wire

// file: core/rccr_pkg.sv
`default_nettype none
package rccr_pkg;
  // register map, one aligned word on the bus
  localparam logic [3:0] RCCR_OFF_CTRL        = 4'h0;  // the reset cause / control register
  localparam logic [3:0] RCCR_OFF_VECTOR      = 4'h4;  // read-only vector address status
  localparam logic [3:0] RCCR_OFF_BROWNOUT_EN = 4'h8;  // read-only effective brown-out enable
  // field positions inside the control register
  localparam int RCCR_BIT_PRIO_EN   = 7;  // priority_level_enable
  localparam int RCCR_BIT_SBOR      = 6;  // software_brownout_enable
  localparam int RCCR_BIT_RST_INSTR = 4;  // reset_instr_flag
  localparam int RCCR_BIT_WDOG_TMO  = 3;  // watchdog_timeout_flag
  localparam int RCCR_BIT_PWR_DOWN  = 2;  // power_down_flag
  localparam int RCCR_BIT_POR       = 1;  // power-on flag
  localparam int RCCR_BIT_BROWN_OUT = 0;  // brown_out_flag
  // reset values
  localparam logic RCCR_RST_PRIO_EN   = 1'h0;
  localparam logic RCCR_RST_SBOR      = 1'h1;
  localparam logic RCCR_RST_RST_INSTR = 1'h1;
  localparam logic RCCR_RST_WDOG_TMO  = 1'h1;
  localparam logic RCCR_RST_PWR_DOWN  = 1'h1;
  localparam logic RCCR_RST_POR       = 1'h0;
  localparam logic RCCR_RST_BROWN_OUT = 1'h0;
  // brown-out configuration code that hands control to software
  localparam logic [1:0] RCCR_BROWNOUT_CFG_SW = 2'h1;
  // interrupt vectors
  localparam logic [23:0] RCCR_VEC_HIGH = 24'h000008;
  localparam logic [23:0] RCCR_VEC_LOW  = 24'h000018;
  // bus responses
  localparam logic [1:0] RCCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCCR_RESP_SLVERR = 2'h2;
  // bus slave states
  typedef enum logic [1:0] {
    RCCR_BUS_IDLE = 2'b00,
    RCCR_BUS_RESP = 2'b01
  } rccr_bus_t;
endpackage
`default_nettype wire

// file: core/rccr_top.sv
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - priority enable low: single-level compatibility mode
// - config 01: written sbor bit switches brown-out
// - other config: sbor ignored, reads zero
// - brown-out: brown-out flag 0, power-on flag unchanged
// - priority enable clear ignores per-source priority
// - vectors 000008h high, 000018h low
module rccr_top (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,           // power-up reset
  input  wire logic [3:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [3:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic [1:0]  i_brownout_config_field, // from the config word
  input  wire logic        i_brownout_event,   // one cycle: brown-out reset seen
  input  wire logic        i_reset_instr,      // one cycle: reset instruction run
  input  wire logic        i_watchdog_timeout, // one cycle: watchdog expired
  input  wire logic        i_sleep_instr,      // one cycle: sleep executed
  input  wire logic        i_watchdog_clear_instruction, // one cycle
  input  wire logic        i_irq_high_prio,    // pending source's priority bit
  output logic             o_priority_level_enable, // priority levels active
  output logic             o_brownout_reset_en,     // brown-out reset enabled
  output logic [23:0]      o_irq_vector             // vector address for interrupts
);
  typedef struct packed {
    logic prio_en;    // priority_level_enable
    logic sbor;       // software_brownout_enable storage
    logic rst_instr;  // reset_instr_flag
    logic wdog_tmo;   // watchdog_timeout_flag
    logic pwr_down;   // power_down_flag
    logic por;        // power-on flag
    logic brown_out;  // brown_out_flag
  } rccr_state_t;
  rccr_state_t st_reg;
  rccr_state_t st_next;

  logic        wr_pulse;
  logic [3:0]  wr_addr;
  logic [7:0]  wr_data;
  logic        wr_lane0;
  logic [3:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        sw_ctrl;   // software owns brown-out enable
  logic [7:0]  ctrl_view; // control register as read

  // true when the config field hands brown-out to software
  function automatic logic rccr_sw_owns(input logic [1:0] cfg);
    rccr_sw_owns = (cfg == rccr_pkg::RCCR_BROWNOUT_CFG_SW);
  endfunction

  assign sw_ctrl = rccr_sw_owns(i_brownout_config_field);

  rccr_axil_slave u_bus (
    .i_clk      (i_clk),
    .i_rst_n    (i_rst_n),
    .i_awaddr   (i_awaddr),
    .i_awvalid  (i_awvalid),
    .o_awready  (o_awready),
    .i_wdata    (i_wdata),
    .i_wstrb    (i_wstrb),
    .i_wvalid   (i_wvalid),
    .o_wready   (o_wready),
    .o_bresp    (o_bresp),
    .o_bvalid   (o_bvalid),
    .i_bready   (i_bready),
    .i_araddr   (i_araddr),
    .i_arvalid  (i_arvalid),
    .o_arready  (o_arready),
    .o_rdata    (o_rdata),
    .o_rresp    (o_rresp),
    .o_rvalid   (o_rvalid),
    .i_rready   (i_rready),
    .o_wr_pulse (wr_pulse),
    .o_wr_addr  (wr_addr),
    .o_wr_data  (wr_data),
    .o_wr_lane0 (wr_lane0),
    .o_rd_addr  (rd_addr),
    .i_rd_data  (rd_data),
    .i_rd_ok    (rd_ok)
  );

  // vector selection honours priority only when levels are enabled
  rccr_vector_sel u_vec (
    .i_prio_en   (st_reg.prio_en),
    .i_high_prio (i_irq_high_prio),
    .o_vector    (o_irq_vector)
  );

  // read view: sbor masked to zero when software does not own it
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[rccr_pkg::RCCR_BIT_PRIO_EN]   = st_reg.prio_en;
    ctrl_view[rccr_pkg::RCCR_BIT_SBOR]      = st_reg.sbor && sw_ctrl;
    ctrl_view[rccr_pkg::RCCR_BIT_RST_INSTR] = st_reg.rst_instr;
    ctrl_view[rccr_pkg::RCCR_BIT_WDOG_TMO]  = st_reg.wdog_tmo;
    ctrl_view[rccr_pkg::RCCR_BIT_PWR_DOWN]  = st_reg.pwr_down;
    ctrl_view[rccr_pkg::RCCR_BIT_POR]       = st_reg.por;
    ctrl_view[rccr_pkg::RCCR_BIT_BROWN_OUT] = st_reg.brown_out;
  end

  // read mux; unmapped offsets answer with an error and zero data
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      rccr_pkg::RCCR_OFF_CTRL: begin
        rd_data = {24'h000000, ctrl_view};
      end
      rccr_pkg::RCCR_OFF_VECTOR: begin
        rd_data = {8'h00, o_irq_vector};
      end
      rccr_pkg::RCCR_OFF_BROWNOUT_EN: begin
        rd_data = {31'h00000000, o_brownout_reset_en};
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  // register update: software write first, hardware events after so they win
  always_comb begin
    st_next = st_reg;
    if (wr_pulse && wr_lane0 && (wr_addr == rccr_pkg::RCCR_OFF_CTRL)) begin
      st_next.prio_en = wr_data[rccr_pkg::RCCR_BIT_PRIO_EN];
      if (sw_ctrl) begin
        st_next.sbor = wr_data[rccr_pkg::RCCR_BIT_SBOR];
      end
      st_next.rst_instr = wr_data[rccr_pkg::RCCR_BIT_RST_INSTR];
      st_next.por       = wr_data[rccr_pkg::RCCR_BIT_POR];
      st_next.brown_out = wr_data[rccr_pkg::RCCR_BIT_BROWN_OUT];
    end
    // reset instruction clears its flag
    if (i_reset_instr) begin
      st_next.rst_instr = 1'b0;
    end
    // brown-out clears its flag; power-on flag stays as software left it
    if (i_brownout_event) begin
      st_next.brown_out = 1'b0;
    end
    // watchdog-clear instruction sets both flags
    if (i_watchdog_clear_instruction) begin
      st_next.wdog_tmo = 1'b1;
      st_next.pwr_down = 1'b1;
    end
    // sleep clears power-down and sets time-out
    if (i_sleep_instr) begin
      st_next.pwr_down = 1'b0;
      st_next.wdog_tmo = 1'b1;
    end
    // a time-out beats any simultaneous set
    if (i_watchdog_timeout) begin
      st_next.wdog_tmo = 1'b0;
    end
  end

  // power-up loads the reset values; flags set by power-up come up high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg.prio_en   <= rccr_pkg::RCCR_RST_PRIO_EN;
      st_reg.sbor      <= rccr_pkg::RCCR_RST_SBOR;
      st_reg.rst_instr <= rccr_pkg::RCCR_RST_RST_INSTR;
      st_reg.wdog_tmo  <= rccr_pkg::RCCR_RST_WDOG_TMO;
      st_reg.pwr_down  <= rccr_pkg::RCCR_RST_PWR_DOWN;
      st_reg.por       <= rccr_pkg::RCCR_RST_POR;
      st_reg.brown_out <= rccr_pkg::RCCR_RST_BROWN_OUT;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from state; brown-out enable also gated by sw_ctrl
  assign o_priority_level_enable = st_reg.prio_en;
  assign o_brownout_reset_en     = st_reg.sbor && sw_ctrl;
endmodule // rccr_top
`default_nettype wire

// file: core/rccr_vector_sel.sv
`timescale 1ns/100ps
`default_nettype none
module rccr_vector_sel (
  input  wire logic        i_prio_en,     // priority levels on
  input  wire logic        i_high_prio,   // source's priority selection
  output logic [23:0]      o_vector       // vector address taken
);
  // compatibility mode ignores the per-source priority and uses the high vector
  always_comb begin
    if (i_prio_en && !i_high_prio) begin
      o_vector = rccr_pkg::RCCR_VEC_LOW;
    end else begin
      o_vector = rccr_pkg::RCCR_VEC_HIGH;
    end
  end
endmodule // rccr_vector_sel
`default_nettype wire

// file: test/rccr_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// port-level checker for the reset cause block
module rccr_top_sva (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [1:0]  i_brownout_config_field,
  input wire logic        i_irq_high_prio,
  input wire logic        o_priority_level_enable,
  input wire logic        o_brownout_reset_en,
  input wire logic [23:0] o_irq_vector
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [3:0] ra_reg;  // address of the read in flight
  // keep the read address, the answer comes one edge later
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) ra_reg <= 4'h0;
    else if (i_arvalid && o_arready) ra_reg <= i_araddr;
  end
  chk_vec_single: assert property (
    !o_priority_level_enable |-> o_irq_vector == 24'h000008)
    else $error("vector not single level");
  chk_vec_high: assert property (
    o_priority_level_enable && i_irq_high_prio |-> o_irq_vector == 24'h000008)
    else $error("high vector wrong");
  chk_vec_low: assert property (
    o_priority_level_enable && !i_irq_high_prio |-> o_irq_vector == 24'h000018)
    else $error("low vector wrong");
  chk_bor_gated: assert property (
    i_brownout_config_field != 2'h1 |-> !o_brownout_reset_en)
    else $error("brown-out enabled outside software mode");
  chk_sbor_reads: assert property (
    o_rvalid && ra_reg == 4'h0 && i_brownout_config_field != 2'h1 |-> o_rdata[6:5] == 2'h0)
    else $error("software enable not read as zero");
  chk_bor_cause: assert property (
    $changed(o_brownout_reset_en) |-> $rose(o_bvalid) || $changed(i_brownout_config_field))
    else $error("brown-out enable moved without cause");
  chk_priority_level_enable_cause: assert property (
    $changed(o_priority_level_enable) |-> $rose(o_bvalid))
    else $error("priority enable moved without a write");
  chk_rd_answer: assert property (
    i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_resp_hold: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
endmodule // rccr_top_sva
bind rccr_top rccr_top_sva u_sva (.i_clk, .i_rst_n, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .o_bresp, .o_bvalid, .i_bready, .i_brownout_config_field,
  .i_irq_high_prio, .o_priority_level_enable, .o_brownout_reset_en, .o_irq_vector);
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CMP(n, e, a) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb;
  typedef struct packed {logic [1:0] c; logic [7:0] w; logic [7:0] e; logic b;} rccr_row_t;
  // config, written byte, expected register, expected brown-out enable
  localparam rccr_row_t ROWS [6] = '{'{2'h1, 8'h00, 8'h0C, 1'b0}, '{2'h1, 8'hE3, 8'hCF, 1'b1},
    '{2'h2, 8'h53, 8'h1F, 1'b0}, '{2'h1, 8'h52, 8'h5E, 1'b1}, '{2'h0, 8'h00, 8'h0C, 1'b0},
    '{2'h3, 8'h80, 8'h8C, 1'b0}};
  // event pulses {brownout, reset instr, timeout, sleep, clear} and register after each
  localparam logic [4:0] EVS [5] = '{5'h04, 5'h02, 5'h01, 5'h10, 5'h08};
  localparam logic [7:0] EVX [5] = '{8'h17, 8'h1B, 8'h1F, 8'h1E, 8'h0E};
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, ws = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, hp = 1'b0;
  logic [1:0]  cfg = 2'h1;
  logic [4:0]  ev = 5'h00;
  logic        awr, wrd, bv, arr, rv, ple, bo_en;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [23:0] vec;
  int          bad_count = 0, checks = 0;
  rccr_top DUT (.i_clk, .i_rst_n, .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy), .i_brownout_config_field(cfg),
    .i_brownout_event(ev[4]), .i_reset_instr(ev[3]), .i_watchdog_timeout(ev[2]),
    .i_sleep_instr(ev[1]), .i_watchdog_clear_instruction(ev[0]), .i_irq_high_prio(hp),
    .o_priority_level_enable(ple), .o_brownout_reset_en(bo_en), .o_irq_vector(vec));
  always #25 i_clk = ~i_clk;
  // write; bready comes late on purpose so the slave must hold its answer
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv);
    brdy <= 1'b1;
    @(posedge i_clk);
    r = bresp;
    brdy <= 1'b0;
    @(posedge i_clk);
  endtask
  // read; address and ready go up together
  task automatic rd(input logic [3:0] a);
    ara <= a; arv <= 1'b1; rrdy <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    d = rdata; r = rresp;
    rrdy <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard, far beyond the some 170 cycles the run needs
  initial begin
    #100000;
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(4'h0);
    `CMP("reset value", 32'h5C, d)
    foreach (ROWS[i]) begin
      cfg <= ROWS[i].c;
      @(posedge i_clk);
      wr(4'h0, {24'h0, ROWS[i].w}, 4'hF);
      `CMP("wr resp", 2'h0, r)
      rd(4'h0);
      `CMP("ctrl", {24'h0, ROWS[i].e}, d)
      `CMP("bo en", ROWS[i].b, bo_en)
      `CMP("prio en", ROWS[i].e[7], ple)
      rd(4'h8);
      `CMP("bo en reg", {31'h0, ROWS[i].b}, d)
    end
    $display("test rows done");
    wr(4'h0, 32'h13, 4'hF);
    foreach (EVS[i]) begin
      ev <= EVS[i];
      @(posedge i_clk);
      ev <= 5'h00;
      @(posedge i_clk);
      rd(4'h0);
      `CMP("event", {24'h0, EVX[i]}, d)
    end
    $display("test events done");
    wr(4'h4, 32'hFF, 4'hF);
    `CMP("ro write", 2'h2, r)
    wr(4'h0, 32'hFF, 4'h0);
    `CMP("no lane", 2'h0, r)
    rd(4'h0);
    `CMP("kept", 32'h0E, d)
    rd(4'hC);
    `CMP("unmapped", 34'h200000000, {r, d})
    $display("test bus done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, {24'h0, i[1], 7'h00}, 4'hF);
      hp <= i[0];
      @(posedge i_clk);
      `CMP("vector", (i[1] && !i[0]) ? 24'h000018 : 24'h000008, vec)
      rd(4'h4);
      `CMP("vector reg", (i[1] && !i[0]) ? 32'h18 : 32'h08, d)
    end
    $display("test vectors done");
    cfg <= 2'h1;
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(4'h0);
    `CMP("rst ctrl", 32'h5C, d)
    `CMP("rst bo en", 1'b1, bo_en)
    `CMP("rst prio en", 1'b0, ple)
    $display("test reset done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
